// *** common/dsss_pkg.sv ***
// Constants shared by the drive shutoff and second-set selection logic.
// Assumes a 32-bit APB register bus and twelve remappable input terminals.
package dsss_pkg;

	// Number of input terminals that carry a remappable function.
	localparam int TERM_COUNT = 12;
	// Number of parameters in each drive parameter set.
	localparam int SET_COUNT  = 8;
	// Width of one drive parameter.
	localparam int PARAM_W    = 16;

	// Function codes held in the terminal mapping entries.
	localparam logic [15:0] FUNC_SECOND_SET = 16'h0003;
	localparam logic [15:0] FUNC_SHUTOFF    = 16'h0018;
	localparam logic [15:0] FUNC_NONE       = 16'h270F;

	// Terminals that carry the two functions after reset.
	localparam int TERM_SECOND_SET = 2;
	localparam int TERM_SHUTOFF    = 3;

	// Shutoff logic setting values.
	localparam logic [7:0] LOGIC_NO = 8'h00;
	localparam logic [7:0] LOGIC_NC = 8'h02;
	// Second-set condition setting values.
	localparam logic [7:0] COND_IMMEDIATE = 8'h00;
	localparam logic [7:0] COND_CONST_SPD = 8'h0A;
	// Value of the user group read selection that unlocks the shutoff logic and second-set condition settings.
	localparam logic [15:0] UGRS_UNLOCK = 16'h0000;

	// Values after reset.
	localparam logic [7:0]  LOGIC_RESET = LOGIC_NO;
	localparam logic [7:0]  COND_RESET  = COND_IMMEDIATE;
	localparam logic [15:0] UGRS_RESET  = 16'h0000;
	localparam logic [15:0] PARAM_RESET = 16'h0000;

	// Register byte offsets.
	localparam logic [7:0] OFS_LOGIC  = 8'h00;
	localparam logic [7:0] OFS_COND   = 8'h04;
	localparam logic [7:0] OFS_UGRS   = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_MAP    = 8'h40;
	localparam logic [7:0] OFS_FIRST  = 8'h80;
	localparam logic [7:0] OFS_SECOND = 8'hC0;

	// Status register bit positions.
	localparam int ST_SHUTOFF = 0;
	localparam int ST_OUTPUT  = 1;
	localparam int ST_SECOND  = 2;
	localparam int ST_COAST   = 3;
	localparam int ST_DECEL   = 4;

	// Run states of the output stage.
	typedef enum logic [1:0] {
		RUN_STOPPED,
		RUN_ACTIVE,
		RUN_DECEL,
		RUN_COAST
	} dsss_run_t;

endpackage

// *** verilog/dsss_top.sv ***
// Output shutoff and second parameter set selection for a motor drive.
// Assumes APB on MCLK, contacts on asynchronous pins, and motor status
// (constant speed, standstill) from control logic on the same clock.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
module dsss_top (
	input  wire logic         MCLK,           // System clock, 40 MHz.
	input  wire logic         RST,            // Synchronous reset, active high.
	input  wire logic [11:0]  TERM_IN,        // Contact input terminals.
	input  wire logic         START_IN,       // Start command contact.
	input  wire logic         CONST_SPEED,    // Motor runs at constant speed.
	input  wire logic         MOTOR_STOPPED,  // Motor has come to rest.
	input  wire logic         PSEL,           // APB select.
	input  wire logic         PENABLE,        // APB enable.
	input  wire logic         PWRITE,         // APB direction, high for write.
	input  wire logic [7:0]   PADDR,          // APB byte address.
	input  wire logic [31:0]  PWDATA,         // APB write data.
	output logic      [31:0]  PRDATA,         // APB read data.
	output logic              PREADY,         // APB ready.
	output logic              PSLVERR,        // APB error for unmapped address.
	output logic              OUT_ENABLE,     // Power output stage enabled.
	output logic              DECEL_REQ,      // Ramped deceleration in progress.
	output logic              COAST_REQ,      // Motor coasting with output off.
	output logic              SECOND_SET_VALID, // Alternate parameter set in use.
	output logic      [127:0] ACTIVE_PARAMS   // Parameter set now in force.
);

	// Synchroniser stages for all contact inputs.
	logic [11:0] term_meta_reg;   // First stage, read only by the second.
	logic [11:0] term_sync_reg;   // Second stage, safe to decode.
	logic        start_meta_reg;  // First stage of the start contact.
	logic        start_sync_reg;  // Second stage of the start contact.

	// Software settings.
	logic [7:0]  logic_reg;       // Shutoff logic setting.
	logic [7:0]  cond_reg;        // Second-set condition setting.
	logic [15:0] ugrs_reg;        // User group read selection.
	logic [15:0] map_reg    [dsss_pkg::TERM_COUNT];  // Terminal mapping.
	logic [15:0] first_reg  [dsss_pkg::SET_COUNT];   // Normal parameter set.
	logic [15:0] second_reg [dsss_pkg::SET_COUNT];   // Alternate parameter set.

	// Run state.
	dsss_pkg::dsss_run_t state_reg;   // Present run state.
	dsss_pkg::dsss_run_t state_next;  // Next run state.

	// Returns a mask of the terminals whose mapping entry holds the given code.
	function automatic logic [11:0] terms_with(input logic [15:0] code,
		input logic [15:0] m [dsss_pkg::TERM_COUNT]);
		logic [11:0] mask;
		mask = 12'h000;
		for (int i = 0; i < dsss_pkg::TERM_COUNT; i++)
		begin
			mask[i] = (m[i] == code);
		end
		return mask;
	endfunction

	// Returns the bits of a set flattened into one word, entry 0 lowest.
	function automatic logic [127:0] flatten(input logic [15:0] s [dsss_pkg::SET_COUNT]);
		logic [127:0] flat;
		flat = 128'h0;
		for (int i = 0; i < dsss_pkg::SET_COUNT; i++)
		begin
			flat[i*16 +: 16] = s[i];
		end
		return flat;
	endfunction

	// Two flip-flops ahead of every decode, so a bouncing contact cannot
	// reach the mapping logic while metastable.
	always_ff @(posedge MCLK)
	begin
		term_meta_reg  <= TERM_IN;
		term_sync_reg  <= term_meta_reg;
		start_meta_reg <= START_IN;
		start_sync_reg <= start_meta_reg;
	end

	// Function decode after synchronisation.
	wire [11:0] shut_mask   = terms_with(dsss_pkg::FUNC_SHUTOFF, map_reg);
	wire [11:0] second_mask = terms_with(dsss_pkg::FUNC_SECOND_SET, map_reg);
	// A closed contact reads high; the NC setting turns an open contact
	// into the active level for the shutoff function only.
	wire        shut_invert = (logic_reg == dsss_pkg::LOGIC_NC);
	wire [11:0] shut_level  = shut_invert ? ~term_sync_reg : term_sync_reg;
	wire        shutoff_act = |(shut_mask & shut_level);
	wire        second_sel  = |(second_mask & term_sync_reg);
	wire        start_act   = start_sync_reg;

	// Second set: immediate, or only while the speed is steady.
	wire        cond_ok     = (cond_reg == dsss_pkg::COND_IMMEDIATE) ||
		((cond_reg == dsss_pkg::COND_CONST_SPD) && CONST_SPEED);
	wire        second_next = second_sel && cond_ok;

	// Whole group switches in one edge, never parameter by parameter.
	wire [127:0] first_flat  = flatten(first_reg);
	wire [127:0] second_flat = flatten(second_reg);
	wire [127:0] params_next = second_next ? second_flat : first_flat;

	// Run state machine. Shutoff is taken from the terminal whatever the
	// command source, since no operation mode input gates it.
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			dsss_pkg::RUN_STOPPED:
				// A start while shutoff is active is simply not taken.
				if (start_act && !shutoff_act)
					state_next = dsss_pkg::RUN_ACTIVE;
			dsss_pkg::RUN_ACTIVE:
				if (shutoff_act)
					state_next = dsss_pkg::RUN_COAST;
				else if (!start_act)
					state_next = dsss_pkg::RUN_DECEL;
			dsss_pkg::RUN_DECEL:
				// Shutoff during the ramp abandons it and lets the motor coast.
				if (shutoff_act)
					state_next = dsss_pkg::RUN_COAST;
				else if (start_act)
					state_next = dsss_pkg::RUN_ACTIVE;
				else if (MOTOR_STOPPED)
					state_next = dsss_pkg::RUN_STOPPED;
			dsss_pkg::RUN_COAST:
				// Leave only once at rest and released, so no restart races it.
				if (MOTOR_STOPPED && !shutoff_act)
					state_next = dsss_pkg::RUN_STOPPED;
		endcase
	end

	// Output stage flags, all registered.
	wire out_next = ((state_next == dsss_pkg::RUN_ACTIVE) ||
		(state_next == dsss_pkg::RUN_DECEL)) && !shutoff_act;

	// Run state and outputs.
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			state_reg        <= dsss_pkg::RUN_STOPPED;
			OUT_ENABLE       <= 1'b0;
			DECEL_REQ        <= 1'b0;
			COAST_REQ        <= 1'b0;
			SECOND_SET_VALID <= 1'b0;
			ACTIVE_PARAMS    <= 128'h0;
		end
		else
		begin
			state_reg        <= state_next;
			OUT_ENABLE       <= out_next;
			DECEL_REQ        <= (state_next == dsss_pkg::RUN_DECEL);
			COAST_REQ        <= (state_next == dsss_pkg::RUN_COAST);
			SECOND_SET_VALID <= second_next;
			ACTIVE_PARAMS    <= params_next;
		end
	end

	// APB decode. Every access completes with no wait state.
	wire        setup_ph  = PSEL && !PENABLE;
	wire        access_ok = PSEL && PENABLE && PREADY;
	wire        wr_en     = access_ok && PWRITE;
	wire        unlocked  = (ugrs_reg == dsss_pkg::UGRS_UNLOCK);
	wire        hit_logic = (PADDR == dsss_pkg::OFS_LOGIC);
	wire        hit_cond  = (PADDR == dsss_pkg::OFS_COND);
	wire        hit_ugrs  = (PADDR == dsss_pkg::OFS_UGRS);
	wire        hit_stat  = (PADDR == dsss_pkg::OFS_STATUS);
	wire        hit_map   = (PADDR[7:6] == 2'h1) && (PADDR[5:2] < 4'hC) && (PADDR[1:0] == 2'h0);
	wire        hit_first = (PADDR[7:5] == 3'h4) && (PADDR[1:0] == 2'h0);
	wire        hit_sec   = (PADDR[7:5] == 3'h6) && (PADDR[1:0] == 2'h0);
	wire        hit_any   = hit_logic || hit_cond || hit_ugrs || hit_stat ||
		hit_map || hit_first || hit_sec;
	wire [3:0]  map_idx   = PADDR[5:2];
	wire [2:0]  set_idx   = PADDR[4:2];
	// Values outside the documented settings are dropped, not stored.
	wire        logic_val = (PWDATA[7:0] == dsss_pkg::LOGIC_NO) ||
		(PWDATA[7:0] == dsss_pkg::LOGIC_NC);
	wire        cond_val  = (PWDATA[7:0] == dsss_pkg::COND_IMMEDIATE) ||
		(PWDATA[7:0] == dsss_pkg::COND_CONST_SPD);

	// Status word, each flag at its named position. The decel flag is taken
	// from the state register, which always agrees with DECEL_REQ.
	logic [31:0] status;   // Read-only status word.
	always_comb
	begin
		status                       = 32'h0;
		status[dsss_pkg::ST_SHUTOFF] = shutoff_act;
		status[dsss_pkg::ST_OUTPUT]  = OUT_ENABLE;
		status[dsss_pkg::ST_SECOND]  = SECOND_SET_VALID;
		status[dsss_pkg::ST_COAST]   = COAST_REQ;
		status[dsss_pkg::ST_DECEL]   = (state_reg == dsss_pkg::RUN_DECEL);
	end

	// Read mux, sampled into PRDATA during the setup cycle.
	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = 32'h0;
		if (hit_logic)
			rd_mux = {24'h0, logic_reg};
		else if (hit_cond)
			rd_mux = {24'h0, cond_reg};
		else if (hit_ugrs)
			rd_mux = {16'h0, ugrs_reg};
		else if (hit_stat)
			rd_mux = status;
		else if (hit_map)
			rd_mux = {16'h0, map_reg[map_idx]};
		else if (hit_first)
			rd_mux = {16'h0, first_reg[set_idx]};
		else if (hit_sec)
			rd_mux = {16'h0, second_reg[set_idx]};
	end

	// Bus answer: ready rises for the access cycle that follows a setup.
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h0;
		end
		else
		begin
			PREADY  <= setup_ph;
			PSLVERR <= setup_ph && !hit_any;
			PRDATA  <= setup_ph ? rd_mux : 32'h0;
		end
	end

	// Setting registers. A locked write completes normally but changes nothing.
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			logic_reg <= dsss_pkg::LOGIC_RESET;
			cond_reg  <= dsss_pkg::COND_RESET;
			ugrs_reg  <= dsss_pkg::UGRS_RESET;
		end
		else
		begin
			if (wr_en && hit_logic && unlocked && logic_val)
				logic_reg <= PWDATA[7:0];
			if (wr_en && hit_cond && unlocked && cond_val)
				cond_reg <= PWDATA[7:0];
			if (wr_en && hit_ugrs)
				ugrs_reg <= PWDATA[15:0];
		end
	end

	// Terminal mapping and parameter sets.
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			for (int i = 0; i < dsss_pkg::TERM_COUNT; i++)
			begin
				map_reg[i] <= (i == dsss_pkg::TERM_SHUTOFF) ? dsss_pkg::FUNC_SHUTOFF :
					(i == dsss_pkg::TERM_SECOND_SET) ? dsss_pkg::FUNC_SECOND_SET :
					dsss_pkg::FUNC_NONE;
			end
			for (int i = 0; i < dsss_pkg::SET_COUNT; i++)
			begin
				first_reg[i]  <= dsss_pkg::PARAM_RESET;
				second_reg[i] <= dsss_pkg::PARAM_RESET;
			end
		end
		else
		begin
			if (wr_en && hit_map)
				map_reg[map_idx] <= PWDATA[15:0];
			if (wr_en && hit_first)
				first_reg[set_idx] <= PWDATA[15:0];
			if (wr_en && hit_sec)
				second_reg[set_idx] <= PWDATA[15:0];
		end
	end

	// Checks on the behaviour above.
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	AST_SHUTOFF_CUTS: assert property (shutoff_act |=> !OUT_ENABLE)
		else $error("Output stayed on under shutoff.");
	AST_NO_START: assert property ((state_reg == dsss_pkg::RUN_STOPPED) && shutoff_act
		|=> (state_reg == dsss_pkg::RUN_STOPPED) && !OUT_ENABLE)
		else $error("Start taken while shutoff active.");
	AST_COAST: assert property ((state_reg != dsss_pkg::RUN_STOPPED) && shutoff_act
		|=> COAST_REQ && !DECEL_REQ)
		else $error("Shutoff did not coast the motor.");
	AST_DECEL: assert property ((state_reg == dsss_pkg::RUN_ACTIVE) && !start_act
		&& !shutoff_act |=> DECEL_REQ && OUT_ENABLE)
		else $error("Start removal did not decelerate.");
	AST_LOGIC_RESET: assert property (disable iff (1'b0) $past(RST) && !RST |->
		(logic_reg == dsss_pkg::LOGIC_NO) && (cond_reg == dsss_pkg::COND_IMMEDIATE))
		else $error("Settings not at initial values.");
	AST_MAP_RESET: assert property (disable iff (1'b0) $past(RST) && !RST |->
		(shut_mask == 12'h008) && (second_mask == 12'h004))
		else $error("Default terminal mapping wrong.");
	AST_IMMEDIATE: assert property ((cond_reg == dsss_pkg::COND_IMMEDIATE) && second_sel
		|=> SECOND_SET_VALID)
		else $error("Second set not taken at once.");
	AST_CONST_ONLY: assert property ((cond_reg == dsss_pkg::COND_CONST_SPD) && !CONST_SPEED
		|=> !SECOND_SET_VALID)
		else $error("Second set used while speed changing.");
	AST_GROUP: assert property (SECOND_SET_VALID && $stable(second_flat)
		|-> ACTIVE_PARAMS == second_flat)
		else $error("Alternate group not applied whole.");
	AST_LOCK: assert property (wr_en && (hit_logic || hit_cond) && !unlocked
		|=> $stable(logic_reg) && $stable(cond_reg))
		else $error("Locked setting changed.");
	// The second stage must always hold the pin as it stood two edges back,
	// so no decode can see a level that skipped the synchroniser.
	AST_SYNC: assert property (term_sync_reg == $past(TERM_IN, 2))
		else $error("Synchroniser bypassed.");
	AST_NC_OPEN: assert property ((logic_reg == dsss_pkg::LOGIC_NC) &&
		(|(shut_mask & ~term_sync_reg)) |=> !OUT_ENABLE)
		else $error("Open contact did not shut off in NC mode.");
	AST_FIRST_SET: assert property (!SECOND_SET_VALID && $stable(first_flat)
		|-> ACTIVE_PARAMS == first_flat)
		else $error("Normal group not applied whole.");
	AST_DECEL_HOLD: assert property (DECEL_REQ && !shutoff_act && !start_act
		&& !MOTOR_STOPPED |=> DECEL_REQ && OUT_ENABLE)
		else $error("Ramp left before standstill.");
	AST_READY: assert property (setup_ph |=> PREADY)
		else $error("Bus access not answered at once.");

	COV_COAST:  cover property ((state_reg == dsss_pkg::RUN_ACTIVE) ##1 COAST_REQ);
	COV_DECEL:  cover property (DECEL_REQ ##[1:20] (state_reg == dsss_pkg::RUN_STOPPED));
	COV_SECOND: cover property ($rose(SECOND_SET_VALID));
	COV_NC:     cover property (shut_invert && shutoff_act);

endmodule

// *** verification/dsss_contacts.sv ***
// Contacts and a plain motor that stand outside the shutoff block.
// Assumes the bench moves the contacts through set_contact after a rising edge.
`timescale 1ns/1ps
module dsss_contacts (
	input  wire logic        MCLK,          // System clock.
	input  wire logic        OUT_ENABLE,    // Drive output on.
	input  wire logic        DECEL_REQ,     // Drive ramping down.
	output logic      [11:0] TERM_IN,       // Contact levels, high when closed.
	output logic             START_IN,      // Start contact.
	output logic             CONST_SPEED,   // Motor at full speed.
	output logic             MOTOR_STOPPED  // Motor at rest.
);
	int speed = 0; // Motor speed in steps.
	int top   = 3; // Steps to full speed; a large value gives a slow motor.

	// All contacts start open.
	initial
	begin
		TERM_IN  = 12'h000;
		START_IN = 1'b0;
	end

	// The motor speeds up only while driven without a ramp; coasting and
	// ramping both slow it, so a slow motor keeps those states visible.
	always @(posedge MCLK)
	begin
		if (OUT_ENABLE && !DECEL_REQ && speed < top)
			speed <= speed + 1;
		else if (!(OUT_ENABLE && !DECEL_REQ) && speed > 0)
			speed <= speed - 1;
	end

	assign CONST_SPEED   = (speed >= top) && OUT_ENABLE && !DECEL_REQ; // Never while ramping.
	assign MOTOR_STOPPED = (speed == 0);                               // Rest.

	// Contact 12 stands for the start contact.
	task automatic set_contact(input int i, input logic v);
		if (i == 12)
			START_IN <= v;
		else
			TERM_IN[i] <= v;
	endtask
endmodule

// *** verification/dsss_top_tb.sv ***
// Self-checking bench for the shutoff and second-set block.
// Assumes dsss_contacts models the contacts and the motor.
`timescale 1ns/1ps
module dsss_top_tb;
	typedef struct {logic [31:0] data; logic err;} dsss_note_t;

	logic         MCLK = 1'b0;   // System clock.
	logic         RST = 1'b1;    // Reset.
	logic         PSEL = 1'b0;   // Bus select.
	logic         PENABLE = 1'b0; // Bus enable.
	logic         PWRITE = 1'b0; // Bus direction.
	logic [7:0]   PADDR = 8'h00; // Bus address.
	logic [31:0]  PWDATA = 32'h0; // Bus write data.
	wire  [11:0]  TERM_IN;       // Contacts.
	wire          START_IN, CONST_SPEED, MOTOR_STOPPED; // Motor side.
	wire  [31:0]  PRDATA;        // Read data.
	wire          PREADY, PSLVERR; // Bus answer.
	wire          OUT_ENABLE, DECEL_REQ, COAST_REQ, SECOND_SET_VALID; // Drive state.
	wire  [127:0] ACTIVE_PARAMS; // Parameters in force.
	wire  [3:0]   pins = {DECEL_REQ, COAST_REQ, SECOND_SET_VALID, OUT_ENABLE}; // Status order.
	int           errors = 0;    // Mismatches.
	int           tests_run = 0; // Comparisons.
	int           seed_v;        // Seed call result.
	dsss_note_t   notes[$];      // Expected read results, oldest first.
	logic [127:0] exp_prm = 128'h0; // Parameter set expected now.
	logic [15:0]  set1[8];       // First set values.
	logic [15:0]  set2[8];       // Second set values.

	// Clock at 40 MHz.
	always #12.5 MCLK = ~MCLK;

	dsss_top i_dut (.MCLK(MCLK), .RST(RST), .TERM_IN(TERM_IN), .START_IN(START_IN),
		.CONST_SPEED(CONST_SPEED), .MOTOR_STOPPED(MOTOR_STOPPED), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .OUT_ENABLE(OUT_ENABLE),
		.DECEL_REQ(DECEL_REQ), .COAST_REQ(COAST_REQ),
		.SECOND_SET_VALID(SECOND_SET_VALID), .ACTIVE_PARAMS(ACTIVE_PARAMS));

	dsss_contacts i_ct (.MCLK(MCLK), .OUT_ENABLE(OUT_ENABLE), .DECEL_REQ(DECEL_REQ),
		.TERM_IN(TERM_IN), .START_IN(START_IN), .CONST_SPEED(CONST_SPEED),
		.MOTOR_STOPPED(MOTOR_STOPPED));

	// One comparison; case inequality so an unknown never matches.
	task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// The watcher takes the oldest note at each completed read.
	always @(posedge MCLK)
	begin
		if (PSEL && PENABLE && PREADY && !PWRITE)
		begin
			check("read data", 128'(notes[0].data), 128'(PRDATA));
			check("slave error", 128'(notes[0].err), 128'(PSLVERR));
			check("parameters", exp_prm, ACTIVE_PARAMS);
			if (PADDR == 8'h0C)
				check("drive pins", 128'(notes[0].data[4:1]), 128'(pins));
			void'(notes.pop_front());
		end
	end

	// One bus transfer, held until ready is seen at a rising edge.
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		PSEL <= 1'b1;
		PADDR <= a;
		PWRITE <= w;
		PWDATA <= d;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		// The slave sets the pace; only the watchdog ends a wait that never ends.
		do
			@(posedge MCLK);
		while (PREADY !== 1'b1);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge MCLK);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
		notes.push_back('{d, e});
		apb(a, 1'b0, 32'h0);
	endtask

	// Contact change, then room for the two sync stages and the state update.
	task automatic set(input int i, input logic v);
		i_ct.set_contact(i, v);
		repeat (5) @(posedge MCLK);
	endtask

	// Bounded wait for the motor to reach a state.
	task automatic wait_mot(input logic cs, input logic st);
		int n;
		n = 0;
		while ((CONST_SPEED !== cs || MOTOR_STOPPED !== st) && n < 500)
		begin
			@(posedge MCLK);
			n++;
		end
		if (n == 500)
		begin
			errors++;
			$display("Error motor state expected %b%b seen %b%b", cs, st, CONST_SPEED,
				MOTOR_STOPPED);
		end
		repeat (6) @(posedge MCLK);
	endtask

	function automatic logic [127:0] pack(input bit sel);
		logic [127:0] p;
		for (int i = 0; i < 8; i++)
			p[16 * i +: 16] = sel ? set2[i] : set1[i];
		return p;
	endfunction

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// A hang ends the run as a mismatch; the tests need well under 10k cycles.
	initial
	begin
		#250000;
		errors++;
		wrap_up();
	end

	// Main sequence.
	initial
	begin
		seed_v = $urandom(32'h50B4);
		i_ct.top = 20;
		repeat (12) @(posedge MCLK);
		RST <= 1'b0;
		@(posedge MCLK);
		rd(8'h00, 32'h0, 1'b0);
		for (int i = 0; i < 12; i++)
			rd(8'h40 + 8'(4 * i), (i == 3) ? 32'h18 : (i == 2) ? 32'h3 : 32'h270F, 1'b0);
		rd(8'h10, 32'h0, 1'b1);
		$display("test reset done");
		set(3, 1'b1);
		set(12, 1'b1);
		rd(8'h0C, 32'h1, 1'b0);
		set(3, 1'b0);
		wait_mot(1'b1, 1'b0);
		rd(8'h0C, 32'h2, 1'b0);
		set(3, 1'b1);
		rd(8'h0C, 32'h9, 1'b0);
		wait_mot(1'b0, 1'b1);
		rd(8'h0C, 32'h9, 1'b0);
		set(3, 1'b0);
		wait_mot(1'b1, 1'b0);
		set(12, 1'b0);
		rd(8'h0C, 32'h12, 1'b0);
		wait_mot(1'b0, 1'b1);
		rd(8'h0C, 32'h0, 1'b0);
		set(12, 1'b1);
		wait_mot(1'b1, 1'b0);
		set(12, 1'b0);
		set(3, 1'b1);
		rd(8'h0C, 32'h9, 1'b0);
		wait_mot(1'b0, 1'b1);
		set(3, 1'b0);
		rd(8'h0C, 32'h0, 1'b0);
		$display("test shutoff done");
		wr(8'h00, 32'h2);
		repeat (5) @(posedge MCLK);
		rd(8'h0C, 32'h1, 1'b0);
		set(3, 1'b1);
		rd(8'h0C, 32'h0, 1'b0);
		wr(8'h00, 32'h1);
		rd(8'h00, 32'h2, 1'b0);
		wr(8'h00, 32'h0);
		set(3, 1'b0);
		wr(8'h08, 32'h1);
		wr(8'h00, 32'h2);
		wr(8'h04, 32'hA);
		rd(8'h00, 32'h0, 1'b0);
		rd(8'h04, 32'h0, 1'b0);
		wr(8'h08, 32'h0);
		wr(8'h54, 32'h18);
		set(5, 1'b1);
		rd(8'h0C, 32'h1, 1'b0);
		set(5, 1'b0);
		rd(8'h0C, 32'h0, 1'b0);
		$display("test settings done");
		for (int i = 0; i < 8; i++)
		begin
			set1[i] = 16'($urandom);
			set2[i] = 16'($urandom);
			wr(8'h80 + 8'(4 * i), {16'h0, set1[i]});
			wr(8'hC0 + 8'(4 * i), {16'h0, set2[i]});
		end
		exp_prm = pack(1'b0);
		rd(8'hC4, {16'h0, set2[1]}, 1'b0);
		set(2, 1'b1);
		exp_prm = pack(1'b1);
		rd(8'h0C, 32'h4, 1'b0);
		set(2, 1'b0);
		exp_prm = pack(1'b0);
		rd(8'h0C, 32'h0, 1'b0);
		wr(8'h04, 32'hA);
		set(2, 1'b1);
		rd(8'h0C, 32'h0, 1'b0);
		set(12, 1'b1);
		wait_mot(1'b1, 1'b0);
		exp_prm = pack(1'b1);
		rd(8'h0C, 32'h6, 1'b0);
		set(12, 1'b0);
		exp_prm = pack(1'b0);
		rd(8'h0C, 32'h12, 1'b0);
		wait_mot(1'b0, 1'b1);
		set(2, 1'b0);
		wr(8'h04, 32'h0);
		wr(8'h5C, 32'h3);
		set(7, 1'b1);
		exp_prm = pack(1'b1);
		rd(8'h0C, 32'h4, 1'b0);
		set(7, 1'b0);
		exp_prm = pack(1'b0);
		rd(8'h0C, 32'h0, 1'b0);
		$display("test second set done");
		wrap_up();
	end
endmodule
